// file: dv/hec_global_ctrl_test.sv
// Self-checking testbench of the error-check global control block.
`timescale 1ns/1ns
`include "hec_map.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errorCnt++; \
	$display("CHECK FAILED at %0t: got %0h expected %0h", $time, (a), (e)); end end
module hec_global_ctrl_test;
	// Clock and reset driven by the bench.
	logic clk = 1'b0;
	logic sysRst = 1'b1;
	// Register port and error inputs, all idle at time zero.
	hec_pkg::hec_req_s req = '0;
	logic rdValid;
	logic [63:0] rdData;
	logic [`HEC_NUM_SRC-1:0] errDetect = '0;
	logic legacyMode = 1'b0;
	logic legParityErr = 1'b0;
	logic legBusCycleErr = 1'b0;
	logic [63:0] legErrAddr = 64'h0;
	logic restartOk = 1'b0;
	logic ipRelated = 1'b0;
	logic hwErrorException;
	logic shutdownReq;
	// Bookkeeping of comparisons, mismatches and elapsed cycles.
	int errorCnt = 0;
	int checked = 0;
	int cycles = 0;
	logic seen;
	logic [63:0] capExp;
	// Design under test.
	hec_global_ctrl dut_u (.clk(clk), .sys_rst(sysRst), .req(req), .rdValid(rdValid),
		.rdData(rdData), .errDetect(errDetect), .legacyMode(legacyMode),
		.legParityErr(legParityErr), .legBusCycleErr(legBusCycleErr),
		.legErrAddr(legErrAddr), .restartOk(restartOk), .ipRelated(ipRelated),
		.hwErrorException(hwErrorException), .shutdownReq(shutdownReq));
	// The clock toggles every half period of 20 ns.
	always #20 clk = ~clk;
	// A hang is cut short after a ceiling far above the expected run length.
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			errorCnt++;
			giveVerdict();
		end
	end
	// Prints the counts and the verdict, then ends the run.
	task automatic giveVerdict();
		$display("Comparisons %0d, mismatches %0d", checked, errorCnt);
		if (errorCnt == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : giveVerdict
	// Holds reset for six cycles, changing it only at falling edges.
	task automatic resetDut();
		@(negedge clk);
		sysRst = 1'b1;
		repeat (6) @(negedge clk);
		sysRst = 1'b0;
	endtask : resetDut
	// Reads one register and compares the answer that stands one cycle after the request.
	task automatic rd(input logic [7:0] idx, input logic [63:0] exp);
		@(negedge clk);
		req.rdEn = 1'b1;
		req.index = idx;
		@(negedge clk);
		req.rdEn = 1'b0;
		`CHK(rdValid, 1'b1)
		`CHK(rdData, exp)
	endtask : rd
	// Writes one whole 64-bit word to a register.
	task automatic wr(input logic [7:0] idx, input logic [63:0] data);
		@(negedge clk);
		req.wrEn = 1'b1;
		req.index = idx;
		req.wrData = data;
		@(negedge clk);
		req.wrEn = 1'b0;
	endtask : wr
	// Pulses error inputs for one cycle, then watches for the exception pulse for eight cycles.
	task automatic fire(input logic [4:0] src, input logic par, input logic bus);
		@(negedge clk);
		errDetect = src;
		legParityErr = par;
		legBusCycleErr = bus;
		@(negedge clk);
		errDetect = '0;
		legParityErr = 1'b0;
		legBusCycleErr = 1'b0;
		seen = 1'b0;
		repeat (8)
		begin
			@(negedge clk);
			if (hwErrorException === 1'b1)
				seen = 1'b1;
		end
	endtask : fire
	// Main sequence of tests.
	initial
	begin
		capExp = {40'h0, `HEC_EXT_COUNT, 4'h0, `HEC_TES_PRESENT, 1'b0, `HEC_EXT_PRESENT,
			`HEC_CTL_PRESENT, `HEC_BANK_COUNT};
		resetDut();
		// Capability contents, reset values and an unmapped index.
		rd(`HEC_IDX_CAP, capExp);
		rd(`HEC_IDX_STATUS, `HEC_ZERO64);
		rd(`HEC_IDX_ENABLE, `HEC_ONES64);
		rd(8'hFF, `HEC_ZERO64);
		wr(`HEC_IDX_CAP, `HEC_ZERO64);
		rd(`HEC_IDX_CAP, capExp);
		$display("Test capability and reset done");
		// Every error source raises the exception and records its context.
		for (int i = 0; i < `HEC_NUM_SRC; i++)
		begin
			restartOk = 1'(i % 2);
			ipRelated = ~restartOk;
			fire(5'(1 << i), 1'b0, 1'b0);
			`CHK(seen, 1'b1)
			rd(`HEC_IDX_STATUS, {61'h0, 1'b1, ipRelated, restartOk});
			wr(`HEC_IDX_STATUS, `HEC_ZERO64);
		end
		rd(`HEC_IDX_STATUS, `HEC_ZERO64);
		$display("Test error sources done");
		// Disabled checking ignores errors; re-enabling restores them.
		wr(`HEC_IDX_ENABLE, `HEC_ZERO64);
		rd(`HEC_IDX_ENABLE, `HEC_ZERO64);
		fire(5'h01, 1'b0, 1'b0);
		`CHK(seen, 1'b0)
		wr(`HEC_IDX_ENABLE, `HEC_ONES64);
		fire(5'h10, 1'b0, 1'b0);
		`CHK(seen, 1'b1)
		wr(`HEC_IDX_STATUS, `HEC_ZERO64);
		$display("Test global enable done");
		// Legacy mode captures type and address, which writes cannot alter.
		legacyMode = 1'b1;
		legErrAddr = 64'h0123456789ABCDEF;
		repeat (4) @(negedge clk);
		fire(5'h00, 1'b1, 1'b0);
		`CHK(seen, 1'b1)
		rd(`HEC_IDX_LEG_TYPE, 64'h0000000000000001);
		rd(`HEC_IDX_LEG_ADDR, 64'h0123456789ABCDEF);
		wr(`HEC_IDX_STATUS, `HEC_ZERO64);
		fire(5'h00, 1'b0, 1'b1);
		`CHK(seen, 1'b1)
		wr(`HEC_IDX_LEG_TYPE, `HEC_ONES64);
		rd(`HEC_IDX_LEG_TYPE, 64'h0000000000000002);
		wr(`HEC_IDX_STATUS, `HEC_ZERO64);
		legacyMode = 1'b0;
		$display("Test legacy capture done");
		// Software sets in-progress; the next error must shut down, and reset clears it.
		wr(`HEC_IDX_STATUS, 64'h0000000000000004);
		rd(`HEC_IDX_STATUS, 64'h0000000000000004);
		fire(5'h02, 1'b0, 1'b0);
		`CHK(seen, 1'b0)
		`CHK(shutdownReq, 1'b1)
		resetDut();
		`CHK(shutdownReq, 1'b0)
		rd(`HEC_IDX_STATUS, `HEC_ZERO64);
		$display("Test shutdown done");
		giveVerdict();
	end
endmodule : hec_global_ctrl_test

// file: src/hec_global_ctrl.sv
// Global control and status logic of the hardware error checking facility.
//
// Function
// - Detected error raises abort-class hardware exception.
// - Sources: bus, ECC, parity, cache, TLB.
// - Legacy mode reports read parity, failed cycles.
// - Legacy capture registers written before exception.
// - Captured information stays readable after exception.
// - Each bank tied to one unit group.
// - Registers reached only via special-register instructions.
// - Capability register read-only, writes ignored.
// - Capability bits 7:0 give bank count.
// - Capability bit 8 shows enable register present.
// - Capability bit 9 shows extended registers present.
// - Capability bit 11 makes status 56:53 architectural; bit 11 reads 1 here, but status 56:53 always read zero.
// - Capability bits 23:16 give extended count.
// - Status bit 0 flags reliable restart.
// - Status bit 1 flags error-related pointer.
// - Status bit 2 set on exception, software writable.
// - Second error while in progress means shutdown.
// - Enable register exists only when bit 8 set.
// - All ones enables, all zeros disables checking.
`timescale 1ns/1ns
`include "hec_map.svh"
module hec_global_ctrl
(
	// Clock and reset.
	input wire logic clk,
	input wire logic sys_rst,
	// Special-register instruction port.
	input wire hec_pkg::hec_req_s req,
	output logic rdValid,
	output logic [63:0] rdData,
	// Error sources: bus, ECC, parity, cache, TLB, one per bank group.
	input wire logic [`HEC_NUM_SRC-1:0] errDetect,
	// Legacy-mode errors: read parity and failed bus cycle.
	input wire logic legacyMode,
	input wire logic legParityErr,
	input wire logic legBusCycleErr,
	input wire logic [63:0] legErrAddr,
	// Context of the interrupted instruction.
	input wire logic restartOk,
	input wire logic ipRelated,
	// Exception and shutdown outputs.
	output logic hwErrorException,
	output logic shutdownReq
);
	// Status register bits.
	logic restartPtrValid;
	logic errorPtrValid;
	logic checkInProgress;
	// Global enable register; all ones after reset.
	logic [63:0] enableReg;
	// Legacy capture registers.
	logic [15:0] legacyErrorType;
	logic [63:0] legacyErrorAddress;
	// Controller state and pending error.
	hec_pkg::hec_state_e state;
	hec_pkg::hec_err_s pend;
	// Next values.
	logic next_restartPtrValid;
	logic next_errorPtrValid;
	logic next_checkInProgress;
	logic [63:0] next_enableReg;
	logic [15:0] next_legacyErrorType;
	logic [63:0] next_legacyErrorAddress;
	hec_pkg::hec_state_e next_state;
	hec_pkg::hec_err_s next_pend;
	logic next_rdValid;
	logic [63:0] next_rdData;
	logic next_hwErrorException;
	logic next_shutdownReq;
	// Two-stage synchronisers for error pins from other units' domains.
	logic [`HEC_NUM_SRC+2:0] syncA;
	logic [`HEC_NUM_SRC+2:0] syncB;
	// Checking active: enable register is all ones.
	logic checkEnabled;
	// Any synchronised error event.
	logic errEvent;
	logic legEvent;

	// Capability word is a constant; writes never touch it.
	function automatic logic [63:0] capWord();
		logic [63:0] w;
		w = `HEC_ZERO64;
		w[`HEC_CAP_CNT_LSB +: 8] = `HEC_BANK_COUNT;
		w[`HEC_CAP_CTLP_BIT] = `HEC_CTL_PRESENT;
		w[`HEC_CAP_EXTP_BIT] = `HEC_EXT_PRESENT;
		w[`HEC_CAP_TESP_BIT] = `HEC_TES_PRESENT;
		w[`HEC_CAP_EXTCNT_LSB +: 8] = `HEC_EXT_COUNT;
		return w;
	endfunction : capWord

	// Synchroniser flops; the first stage feeds only the second.
	always_ff @(posedge clk)
	begin
		syncA <= {legBusCycleErr, legParityErr, legacyMode, errDetect};
		syncB <= syncA;
	end

	// Derived terms from synchronised inputs.
	always_comb
	begin
		checkEnabled = (enableReg == `HEC_ONES64) || (`HEC_CTL_PRESENT == 1'h0);
		legEvent = syncB[`HEC_NUM_SRC] && (syncB[`HEC_NUM_SRC+1] || syncB[`HEC_NUM_SRC+2]);
		errEvent = checkEnabled && ((|syncB[`HEC_NUM_SRC-1:0]) || legEvent);
	end

	// Next-state, register and read logic.
	always_comb
	begin
		next_restartPtrValid = restartPtrValid;
		next_errorPtrValid = errorPtrValid;
		next_checkInProgress = checkInProgress;
		next_enableReg = enableReg;
		next_legacyErrorType = legacyErrorType;
		next_legacyErrorAddress = legacyErrorAddress;
		next_state = state;
		next_pend = pend;
		next_hwErrorException = 1'b0;
		next_shutdownReq = shutdownReq;
		next_rdValid = req.rdEn;
		next_rdData = `HEC_ZERO64;
		// Register reads through the special-register read instruction.
		unique case (req.index)
			`HEC_IDX_CAP: next_rdData = capWord();
			`HEC_IDX_STATUS:
			begin
				next_rdData[`HEC_ST_RESTART_PTR_VALID_BIT] = restartPtrValid;
				next_rdData[`HEC_ST_ERROR_PTR_VALID_BIT] = errorPtrValid;
				next_rdData[`HEC_ST_INPROG_BIT] = checkInProgress;
			end
			`HEC_IDX_ENABLE: next_rdData = enableReg;
			`HEC_IDX_LEG_TYPE: next_rdData[15:0] = legacyErrorType;
			`HEC_IDX_LEG_ADDR: next_rdData = legacyErrorAddress;
			default: next_rdData = `HEC_ZERO64;
		endcase
		if (!req.rdEn)
		begin
			next_rdData = `HEC_ZERO64;
		end
		// Register writes; capability writes are dropped.
		if (req.wrEn)
		begin
			if (req.index == `HEC_IDX_STATUS)
			begin
				next_restartPtrValid = req.wrData[`HEC_ST_RESTART_PTR_VALID_BIT];
				next_errorPtrValid = req.wrData[`HEC_ST_ERROR_PTR_VALID_BIT];
				next_checkInProgress = req.wrData[`HEC_ST_INPROG_BIT];
			end
			else if (req.index == `HEC_IDX_ENABLE && `HEC_CTL_PRESENT == 1'h1)
			begin
				next_enableReg = req.wrData;
			end
		end
		// Error handling sequence.
		unique case (state)
			hec_pkg::HEC_RUN:
			begin
				if (errEvent)
				begin
					next_pend.valid = 1'b1;
					next_pend.legacy = legEvent;
					next_pend.legType = {14'h0000, syncB[`HEC_NUM_SRC+2], syncB[`HEC_NUM_SRC+1]};
					next_pend.addr = legErrAddr;
					next_pend.restartOk = restartOk;
					next_pend.ipRelated = ipRelated;
					next_pend.source = syncB[`HEC_NUM_SRC-1:0];
					if (checkInProgress)
					begin
						next_state = hec_pkg::HEC_SHUTDOWN;
					end
					else
					begin
						next_state = hec_pkg::HEC_CAPTURE;
					end
				end
			end
			hec_pkg::HEC_CAPTURE:
			begin
				// Legacy capture happens a cycle ahead of the exception.
				if (pend.legacy)
				begin
					next_legacyErrorType = pend.legType;
					next_legacyErrorAddress = pend.addr;
				end
				next_state = hec_pkg::HEC_RAISE;
			end
			hec_pkg::HEC_RAISE:
			begin
				next_hwErrorException = 1'b1;
				next_checkInProgress = 1'b1;
				next_restartPtrValid = pend.restartOk;
				next_errorPtrValid = pend.ipRelated;
				next_pend.valid = 1'b0;
				next_state = hec_pkg::HEC_RUN;
			end
			hec_pkg::HEC_SHUTDOWN:
			begin
				next_shutdownReq = 1'b1;
			end
		endcase
	end

	// State registers with synchronous reset.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			restartPtrValid <= 1'b0;
			errorPtrValid <= 1'b0;
			checkInProgress <= 1'b0;
			enableReg <= `HEC_ONES64;
			legacyErrorType <= 16'h0000;
			legacyErrorAddress <= `HEC_ZERO64;
			state <= hec_pkg::HEC_RUN;
			pend <= '0;
			rdValid <= 1'b0;
			rdData <= `HEC_ZERO64;
			hwErrorException <= 1'b0;
			shutdownReq <= 1'b0;
		end
		else
		begin
			restartPtrValid <= next_restartPtrValid;
			errorPtrValid <= next_errorPtrValid;
			checkInProgress <= next_checkInProgress;
			enableReg <= next_enableReg;
			legacyErrorType <= next_legacyErrorType;
			legacyErrorAddress <= next_legacyErrorAddress;
			state <= next_state;
			pend <= next_pend;
			rdValid <= next_rdValid;
			rdData <= next_rdData;
			hwErrorException <= next_hwErrorException;
			shutdownReq <= next_shutdownReq;
		end
	end

	// The pulse is seen three edges after an accepted error: capture, raise, then the flop.
	property p_raise;
		@(posedge clk) disable iff (sys_rst)
		(state == hec_pkg::HEC_RUN && errEvent && !checkInProgress) |-> ##3 hwErrorException;
	endproperty
	a_raise: assert property (p_raise) else $error("exception not raised");
	// Exception sets the in-progress bit.
	property p_inprog;
		@(posedge clk) disable iff (sys_rst)
		hwErrorException |-> checkInProgress;
	endproperty
	a_inprog: assert property (p_inprog) else $error("in-progress not set");
	// Second error while in progress leads to shutdown, never an exception.
	property p_shut;
		@(posedge clk) disable iff (sys_rst)
		(state == hec_pkg::HEC_RUN && errEvent && checkInProgress) |-> (##2 shutdownReq)
		and (##1 (!hwErrorException) [*4]);
	endproperty
	a_shut: assert property (p_shut) else $error("no shutdown on nested error");
	// Legacy capture is visible when the exception fires.
	property p_legacy;
		@(posedge clk) disable iff (sys_rst)
		(hwErrorException && pend.legacy) |-> legacyErrorAddress == pend.addr;
	endproperty
	a_legacy: assert property (p_legacy) else $error("legacy capture late");
	// Capability read returns the constant word.
	property p_cap;
		@(posedge clk) disable iff (sys_rst)
		(req.rdEn && req.index == `HEC_IDX_CAP) |=> rdValid && rdData == capWord();
	endproperty
	a_cap: assert property (p_cap) else $error("capability read wrong");
	// Enable write of zeros disables new exceptions.
	property p_disable;
		@(posedge clk) disable iff (sys_rst)
		(enableReg == `HEC_ZERO64 && state == hec_pkg::HEC_RUN) |=> state == hec_pkg::HEC_RUN;
	endproperty
	a_disable: assert property (p_disable) else $error("disabled checking still acts");
	// Status read reflects restart bit.
	property p_restart_ptr_valid;
		@(posedge clk) disable iff (sys_rst)
		(req.rdEn && req.index == `HEC_IDX_STATUS && !req.wrEn && state != hec_pkg::HEC_RAISE)
		|=> rdData[`HEC_ST_RESTART_PTR_VALID_BIT] == restartPtrValid;
	endproperty
	a_restart_ptr_valid: assert property (p_restart_ptr_valid) else $error("status read wrong");
	// Error-pointer bit loads from context on exception.
	property p_error_ptr_valid;
		@(posedge clk) disable iff (sys_rst)
		hwErrorException |-> errorPtrValid == $past(pend.ipRelated);
	endproperty
	a_error_ptr_valid: assert property (p_error_ptr_valid) else $error("pointer bit wrong");
	// Every read request is answered on the next edge.
	property p_rdvalid;
		@(posedge clk) disable iff (sys_rst)
		req.rdEn |=> rdValid;
	endproperty
	a_rdvalid: assert property (p_rdvalid) else $error("read not answered");
	// Reset clears the restart, pointer and in-progress bits and the shutdown request.
	property p_rstclr;
		@(posedge clk)
		sys_rst |=> !restartPtrValid && !errorPtrValid && !checkInProgress && !shutdownReq;
	endproperty
	a_rstclr: assert property (p_rstclr) else $error("status not cleared by reset");
	// Main scenarios.
	c_raise: cover property (@(posedge clk) hwErrorException);
	c_shut: cover property (@(posedge clk) shutdownReq);
	c_legacy: cover property (@(posedge clk) hwErrorException && pend.legacy);
	c_ignored: cover property (@(posedge clk) !checkEnabled && (|syncB[`HEC_NUM_SRC-1:0]));
endmodule : hec_global_ctrl

// file: src/hec_map.svh
// Register indices, field positions, reset values and build constants of the error-check control block.
`ifndef HEC_MAP_SVH
`define HEC_MAP_SVH
// Special-register indices; the values are arbitrary.
`define HEC_IDX_CAP 8'h00
`define HEC_IDX_STATUS 8'h01
`define HEC_IDX_ENABLE 8'h02
`define HEC_IDX_LEG_TYPE 8'h03
`define HEC_IDX_LEG_ADDR 8'h04
// Capability field positions.
`define HEC_CAP_CNT_LSB 0
`define HEC_CAP_CTLP_BIT 8
`define HEC_CAP_EXTP_BIT 9
`define HEC_CAP_TESP_BIT 11
`define HEC_CAP_EXTCNT_LSB 16
// Status field positions.
`define HEC_ST_RESTART_PTR_VALID_BIT 0
`define HEC_ST_ERROR_PTR_VALID_BIT 1
`define HEC_ST_INPROG_BIT 2
// Build figures.
`define HEC_BANK_COUNT 8'h05
`define HEC_EXT_COUNT 8'h00
`define HEC_CTL_PRESENT 1'h1
`define HEC_EXT_PRESENT 1'h0
`define HEC_TES_PRESENT 1'h1
// Error source count and reset values.
`define HEC_NUM_SRC 5
`define HEC_ZERO64 64'h0000000000000000
`define HEC_ONES64 64'hFFFFFFFFFFFFFFFF
`endif

// file: src/hec_pkg.sv
// Types shared by the error-check control block.
package hec_pkg;
	// Register access request from the special-register instructions.
	typedef struct packed {
		logic rdEn;
		logic wrEn;
		logic [7:0] index;
		logic [63:0] wrData;
	} hec_req_s;
	// One reported error with its context.
	typedef struct packed {
		logic valid;
		logic [4:0] source;
		logic legacy;
		logic [15:0] legType;
		logic [63:0] addr;
		logic restartOk;
		logic ipRelated;
	} hec_err_s;
	// Controller state.
	typedef enum logic [1:0] {
		HEC_RUN = 2'b00,
		HEC_CAPTURE = 2'b01,
		HEC_RAISE = 2'b10,
		HEC_SHUTDOWN = 2'b11
	} hec_state_e;
endpackage : hec_pkg
